//--- hif_pkg.sv
// Constants for the host identifier feature command handler.
// Assumes a command front end that presents decoded feature commands.
// Summary of operation
// - Dword 11 bit 0 selects 128-bit identifier; bits 31:1 reserved.
// - Wide select without wide support completes Invalid Field in Command.
// - Width mismatch with another controller completes Inconsistent Format.
// - Identifier buffer is 8 bytes narrow, 16 bytes wide.
// - Get feature 81h returns stored identifier in data buffer.
// - Equal non-zero identifiers of equal width mean same host, sharing reservation rights.
// - Zero identifier is valid; two zeros mean different hosts.
// - On PCIe the feature is optional; narrow and/or wide width supported.
// - On PCIe a set feature may change the identifier at any time.
// - On fabrics the identifier is always the 128-bit form; wide_id_select stays 0 from reset until connect_load.
// - On fabrics a set feature for this feature aborts Command Sequence Error.
// - On fabrics a narrow get feature aborts Invalid Field in Command.
// - A completion entry is posted in the same cycle as the feature is applied.
package hif_pkg;
    localparam logic [7:0]  FID_HOST_IDENT    = 8'h81;
    localparam int          WIDE_SEL_BIT      = 0;
    localparam int          ID_BITS           = 128;
    localparam int          NARROW_BITS       = 64;
    localparam logic [7:0]  SC_SUCCESS        = 8'h00;
    localparam logic [7:0]  SC_INVALID_FIELD  = 8'h02;
    localparam logic [7:0]  SC_CMD_SEQ_ERROR  = 8'h0C;
    localparam logic [7:0]  SC_ID_INCONSIST   = 8'h14;
    localparam logic [127:0] ID_RESET         = 128'h0;
    typedef enum logic [2:0] {
        HIF_IDLE  = 3'b001,
        HIF_EXEC  = 3'b010,
        HIF_DONE  = 3'b100
    } hif_state_e;
endpackage : hif_pkg

//--- hif_host_ident.sv
// Host identifier feature handler: set/get, status, same-host compare.
// Assumes a one-command-at-a-time front end and a single clock.
`timescale 1ns/1ps
module hif_host_ident #(
    parameter bit WIDE_SUPPORTED   = 1'b1,
    parameter bit NARROW_SUPPORTED = 1'b1
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          reset,
    // Transport: high for fabrics, low for PCIe
    input  wire logic          fabrics_mode,
    // Command request
    input  wire logic          cmd_valid,
    input  wire logic          cmd_is_set,
    input  wire logic [7:0]    cmd_fid,
    input  wire logic [31:0]   cmd_dw11,
    input  wire logic [127:0]  cmd_data,
    // Connect-time load on fabrics
    input  wire logic          connect_load,
    input  wire logic [127:0]  connect_ident,
    // Width in use by other controllers in the subsystem
    input  wire logic          peer_present,
    input  wire logic          peer_wide,
    // Peer identifier for same-host check
    input  wire logic [127:0]  peer_ident,
    input  wire logic          peer_ident_wide,
    // Completion
    output logic               cpl_valid,
    output logic [7:0]         cpl_status,
    output logic [127:0]       cpl_data,
    output logic               cmd_ready,
    // Stored state
    output logic [127:0]       host_ident_value,
    output logic               wide_id_select,
    output logic               same_host
);
    import hif_pkg::*;

    // Refuse a build that supports no width at all
    if (!WIDE_SUPPORTED && !NARROW_SUPPORTED) begin : g_no_width
        $error("At least one identifier width must be supported");
    end

    hif_state_e state;
    logic       req_set;
    logic       req_wide;
    logic [127:0] req_data;

    function automatic logic [7:0] check(input logic is_set, input logic wide, input logic fab);
        if (fab && is_set)
            check = SC_CMD_SEQ_ERROR;
        else if (fab && !wide)
            check = SC_INVALID_FIELD;
        else if (wide && !WIDE_SUPPORTED)
            check = SC_INVALID_FIELD;
        else if (!wide && !NARROW_SUPPORTED && !fab)
            check = SC_INVALID_FIELD;
        else if (is_set && peer_present && peer_wide != wide)
            check = SC_ID_INCONSIST;
        else
            check = SC_SUCCESS;
    endfunction : check

    // Command sequencing
    always_ff @(posedge clock) begin
        if (reset) begin
            state    <= HIF_IDLE;
            req_set  <= 1'b0;
            req_wide <= 1'b0;
            req_data <= ID_RESET;
        end else begin
            unique case (state)
                HIF_IDLE: begin
                    if (cmd_valid && cmd_fid == FID_HOST_IDENT) begin
                        state    <= HIF_EXEC;
                        req_set  <= cmd_is_set;
                        req_wide <= cmd_dw11[WIDE_SEL_BIT];
                        req_data <= cmd_data;
                    end
                end
                HIF_EXEC: state <= HIF_DONE;
                HIF_DONE: state <= HIF_IDLE;
                default:  state <= HIF_IDLE;
            endcase
        end
    end

    // Stored identifier
    always_ff @(posedge clock) begin
        if (reset) begin
            host_ident_value <= ID_RESET;
            wide_id_select   <= 1'b0;
        end else if (fabrics_mode && connect_load) begin
            host_ident_value <= connect_ident;
            wide_id_select   <= 1'b1;
        end else if (state == HIF_EXEC && req_set
                     && check(req_set, req_wide, fabrics_mode) == SC_SUCCESS) begin
            wide_id_select   <= req_wide;
            host_ident_value <= req_wide ? req_data
                : {{(ID_BITS-NARROW_BITS){1'b0}}, req_data[NARROW_BITS-1:0]};
        end
    end

    // Completion
    always_ff @(posedge clock) begin
        if (reset) begin
            cpl_valid  <= 1'b0;
            cpl_status <= SC_SUCCESS;
            cpl_data   <= ID_RESET;
            cmd_ready  <= 1'b0;
        end else begin
            cmd_ready <= (state == HIF_IDLE) && !(cmd_valid && cmd_fid == FID_HOST_IDENT);
            cpl_valid <= (state == HIF_EXEC);
            if (state == HIF_EXEC) begin
                cpl_status <= check(req_set, req_wide, fabrics_mode);
                if (!req_set && check(req_set, req_wide, fabrics_mode) == SC_SUCCESS)
                    cpl_data <= req_wide ? host_ident_value
                        : {{(ID_BITS-NARROW_BITS){1'b0}}, host_ident_value[NARROW_BITS-1:0]};
                else
                    cpl_data <= ID_RESET;
            end
        end
    end

    // Same host only for equal non-zero identifiers of equal width
    always_ff @(posedge clock) begin
        if (reset)
            same_host <= 1'b0;
        else
            same_host <= (peer_ident == host_ident_value)
                && (peer_ident_wide == wide_id_select)
                && (host_ident_value != ID_RESET);
    end
endmodule : hif_host_ident

//--- hif_peer_model.sv
// Peer controller model: another controller's identifier and width.
// Assumes the bench holds presence as a static level between commands.
`timescale 1ns/1ps
module hif_peer_model #(parameter logic [127:0] PEER_ID = 128'h0) (
    // Bench control
    input  wire logic present,
    // Toward the handler
    output logic         peer_present,
    output logic         peer_wide,
    output logic [127:0] peer_ident,
    output logic         peer_ident_wide
);
    assign peer_present    = present;
    assign peer_wide       = present;
    // Absent peer shows a value that never matches
    assign peer_ident      = present ? PEER_ID : ~PEER_ID;
    assign peer_ident_wide = present;
endmodule : hif_peer_model

//--- hif_host_ident_assertions.sv
// Port checker for the host identifier handler.
// Assumes it is bound onto every hif_host_ident instance.
`timescale 1ns/1ps
module hif_host_ident_chk import hif_pkg::*; (
    input wire logic         clock, reset, fabrics_mode, cmd_valid, cmd_is_set, connect_load,
    input wire logic [7:0]   cmd_fid, cpl_status,
    input wire logic [31:0]  cmd_dw11,
    input wire logic [127:0] cmd_data, connect_ident, host_ident_value,
    input wire logic         peer_present, peer_wide, cpl_valid, cmd_ready, wide_id_select, same_host
);
    wire tk = cmd_valid && cmd_fid == FID_HOST_IDENT && cmd_ready;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_answer_two: assert property (tk |-> ##2 cpl_valid)
        else $error("completion not two cycles after take");
    a_pulse_one: assert property (cpl_valid |=> !cpl_valid)
        else $error("completion pulse too long");
    a_fab_set: assert property (tk && fabrics_mode && cmd_is_set |-> ##2 cpl_status == SC_CMD_SEQ_ERROR)
        else $error("fabrics set not refused");
    a_fab_narrow: assert property (tk && fabrics_mode && !cmd_is_set && !cmd_dw11[0]
        |-> ##2 cpl_status == SC_INVALID_FIELD) else $error("fabrics narrow get not refused");
    a_mixed_width: assert property (tk && !fabrics_mode && cmd_is_set && peer_present && peer_wide != cmd_dw11[0]
        |-> ##2 cpl_status == SC_ID_INCONSIST) else $error("width clash not reported");
    a_wide_store: assert property (tk && !fabrics_mode && cmd_is_set && cmd_dw11[0] && !(peer_present && !peer_wide)
        |-> ##2 host_ident_value == $past(cmd_data, 2) && wide_id_select) else $error("wide set not stored");
    a_narrow_upper: assert property (!wide_id_select |-> host_ident_value[127:64] == 64'h0)
        else $error("narrow identifier has upper bits");
    a_zero_nomatch: assert property (host_ident_value == 128'h0 ##1 host_ident_value == 128'h0 |-> !same_host)
        else $error("zero identifier matched");
    a_connect_wide: assert property ($past(connect_load) && fabrics_mode |-> wide_id_select
        && host_ident_value == $past(connect_ident)) else $error("connect load not wide");
    c_set: cover property (tk && cmd_is_set);
    c_fab: cover property (tk && fabrics_mode);
    c_same: cover property (same_host);
endmodule : hif_host_ident_chk
bind hif_host_ident hif_host_ident_chk u_chk (.*);

//--- test_host_identifier_feature.sv
// Self-checking bench for the host identifier handler.
// Assumes the peer model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_host_identifier_feature;
    import hif_pkg::*;
    typedef struct packed {logic s, w, pp; logic [127:0] d; logic [7:0] st; logic [127:0] rd; logic sh;} hif_row_s;
    localparam logic [127:0] A = 128'h0123456789ABCDEFFEDCBA9876543210;
    localparam logic [127:0] B = 128'h5555AAAA5555AAAA0F1E2D3C4B5A6978;
    hif_row_s     rows [9];
    logic         clock = 0, reset = 1, fab = 0, cv = 0, cs = 0, cl = 0, pp = 0;
    logic [31:0]  dw = 0;
    logic [127:0] cd = 0, cpl_data, host_ident_value, p_id;
    logic [7:0]   cpl_status;
    logic         cpl_valid, cmd_ready, wide_id_select, same_host, p_pr, p_w, p_iw;
    int           error_cnt = 0, compares = 0;
    always #2.5 clock = ~clock;
    hif_peer_model #(.PEER_ID(A)) peer (.present(pp), .peer_present(p_pr), .peer_wide(p_w), .peer_ident(p_id),
        .peer_ident_wide(p_iw));
    hif_host_ident uut (.clock(clock), .reset(reset), .fabrics_mode(fab), .cmd_valid(cv), .cmd_is_set(cs),
        .cmd_fid(FID_HOST_IDENT), .cmd_dw11(dw), .cmd_data(cd), .connect_load(cl), .connect_ident(B),
        .peer_present(p_pr), .peer_wide(p_w), .peer_ident(p_id), .peer_ident_wide(p_iw), .cpl_valid(cpl_valid),
        .cpl_status(cpl_status), .cpl_data(cpl_data), .cmd_ready(cmd_ready), .host_ident_value(host_ident_value),
        .wide_id_select(wide_id_select), .same_host(same_host));
    task automatic chk(logic [135:0] got, logic [135:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("Counts: %0d mismatches in %0d compares", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic run(int lo, int hi);
        for (int i = lo; i <= hi; i++) begin
            @(posedge clock);
            #1 {cv, cs, dw, cd, pp} = {1'b1, rows[i].s, 31'h0, rows[i].w, rows[i].d, rows[i].pp};
            @(posedge clock);
            #1 cv = 0;
            @(posedge clock);
            #1 chk({cpl_valid, cpl_status}, {1'b1, rows[i].st});
            chk(cmd_ready, 1'b0);
            chk(cpl_data, rows[i].rd);
            @(posedge clock);
            #1 chk(same_host, rows[i].sh);
            $display("Row %0d done", i);
        end
    endtask : run
    initial begin
        rows = '{'{1, 1, 1, A, 8'h00, 0, 1}, '{0, 1, 1, 0, 8'h00, A, 1}, '{1, 0, 1, B, 8'h14, 0, 1},
            '{1, 0, 0, B, 8'h00, 0, 0}, '{0, 1, 0, 0, 8'h00, {64'h0, B[63:0]}, 0}, '{1, 1, 0, 0, 8'h00, 0, 0},
            '{1, 1, 0, A, 8'h0C, 0, 0}, '{0, 0, 0, 0, 8'h02, 0, 0}, '{0, 1, 0, 0, 8'h00, B, 0}};
        for (int ph = 0; ph < 2; ph++) begin
            fab = ph;
            reset = 1;
            repeat (4) @(posedge clock);
            #1 reset = 0;
            chk({cpl_valid, cmd_ready, same_host, wide_id_select, host_ident_value}, 0);
            repeat (2) @(posedge clock);
            #1 cl = ph;
            @(posedge clock);
            #1 cl = 0;
            if (ph) run(6, 8); else run(0, 5);
        end
        end_of_test;
    end
    initial begin
        #2000;
        error_cnt++;
        end_of_test;
    end
endmodule : test_host_identifier_feature
